// ==== rtl/otpg_pkg.sv ====
// Package of constants and types for the output test pattern generator
package otpg_pkg;
    localparam int OTPG_W = 14;
    localparam int OTPG_USER_N = 4;
    // Register indices; byte address is index times four
    localparam logic [11:0] IDX_TEST_SEL = 12'h550;
    localparam logic [11:0] IDX_USER_BASE = 12'h551;
    localparam logic [11:0] IDX_USER_LAST = 12'h558;
    localparam logic [11:0] IDX_OUT_FMT = 12'h561;
    localparam logic [11:0] IDX_STATUS = 12'h570;
    // Field positions of the test select register
    localparam int POS_CODE = 0;
    localparam int POS_RST_LONG = 4;
    localparam int POS_RST_SHORT = 5;
    localparam int POS_SINGLE = 7;
    // Reset values
    localparam logic [7:0] RST_TEST_SEL = 8'h00;
    localparam logic [7:0] RST_USER = 8'h00;
    localparam logic [7:0] RST_OUT_FMT = 8'h01;
    // Test codes
    localparam logic [3:0] CODE_OFF = 4'h0;
    localparam logic [3:0] CODE_MID = 4'h1;
    localparam logic [3:0] CODE_PFS = 4'h2;
    localparam logic [3:0] CODE_NFS = 4'h3;
    localparam logic [3:0] CODE_CHECK = 4'h4;
    localparam logic [3:0] CODE_PN_LONG = 4'h5;
    localparam logic [3:0] CODE_PN_SHORT = 4'h6;
    localparam logic [3:0] CODE_TOGGLE = 4'h7;
    localparam logic [3:0] CODE_USER = 4'h8;
    localparam logic [3:0] CODE_RAMP = 4'hF;
    // Pattern words
    localparam logic [13:0] WORD_MID = 14'h0000;
    localparam logic [13:0] WORD_PFS = 14'h1FFF;
    localparam logic [13:0] WORD_NFS = 14'h2000;
    localparam logic [13:0] WORD_CHECK_A = 14'h1555;
    localparam logic [13:0] WORD_CHECK_B = 14'h2AAA;
    localparam logic [13:0] WORD_ZERO = 14'h0000;
    localparam logic [13:0] WORD_ONES = 14'h3FFF;
    localparam logic [22:0] SEED_PN_LONG = 23'h003AFF;
    localparam logic [8:0] SEED_PN_SHORT = 9'h092;
    // Number formats
    localparam logic [1:0] FMT_OFFSET = 2'h0;
    localparam logic [1:0] FMT_TWOS = 2'h1;
    localparam logic [1:0] FMT_GRAY = 2'h2;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic single;
        logic spare;
        logic rst_short;
        logic rst_long;
        logic [3:0] code;
    } otpg_ctrl_t;

    typedef enum logic [1:0] {
        USR_RUN = 2'b01,
        USR_DONE = 2'b10
    } otpg_usr_state_t;
endpackage

// ==== rtl/otpg_top.sv ====
// Test pattern generator with APB registers and output FIFO
`timescale 1ns/10ps

module otpg_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign push = ce && in_valid && in_ready;
    assign pop = ce && (count_reg != '0) && (!out_valid || out_ready);
    assign level = count_reg;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered output stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (ce) begin
            if (pop) begin
                out_valid <= 1'b1;
                out_data <= mem_reg[rd_ptr_reg];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

    a_fifo_full: assert property (@(posedge clk) disable iff (!rst_n)
        (count_reg == (AW+1)'(DEPTH)) |-> !in_ready)
        else $error("fifo accepts while full");
endmodule

module otpg_top
    import otpg_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [13:0] ADC_DATA,
    output logic [13:0] OUT_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY
);
    otpg_ctrl_t ctrl_reg;
    logic [7:0] user_reg [2*OTPG_USER_N];
    logic [1:0] fmt_reg;
    logic [31:0] rdata_next;
    logic err_next;
    logic [11:0] idx;
    logic wr_en;
    logic [22:0] pn_long_reg;
    logic [8:0] pn_short_reg;
    logic [36:0] pn_long_next;
    logic [22:0] pn_short_next;
    logic [13:0] ramp_reg;
    logic phase_reg;
    logic [1:0] usr_idx_reg;
    otpg_usr_state_t usr_state_reg;
    logic [3:0] code_prev_reg;
    logic [13:0] raw_word;
    logic [13:0] user_word;
    logic [15:0] user_pair;
    logic [13:0] fifo_in;
    logic fifo_ready;
    logic push;
    logic code_same;
    logic [$clog2(DEPTH):0] level;
    logic [13:0] last_raw_reg;
    logic last_same_reg;

    function automatic logic [13:0] fmt_word(input logic [13:0] t, input logic [1:0] f);
        logic [13:0] ob;
        ob = {~t[13], t[12:0]};
        case (f)
            FMT_OFFSET: fmt_word = ob;
            FMT_GRAY: fmt_word = ob ^ (ob >> 1);
            default: fmt_word = t;
        endcase
    endfunction

    // Fourteen shifts per sample, shifted-out bits form the word MSB first
    function automatic logic [36:0] pn_long_step(input logic [22:0] s);
        logic [22:0] st;
        logic [13:0] w;
        logic fb;
        st = s;
        w = '0;
        for (int i = 0; i < OTPG_W; i++) begin
            w = {w[12:0], st[0]};
            fb = st[0] ^ st[5];
            st = {fb, st[22:1]};
        end
        pn_long_step = {st, w};
    endfunction

    function automatic logic [22:0] pn_short_step(input logic [8:0] s);
        logic [8:0] st;
        logic [13:0] w;
        logic fb;
        st = s;
        w = '0;
        for (int i = 0; i < OTPG_W; i++) begin
            w = {w[12:0], st[8]};
            fb = st[8] ^ st[4];
            st = {st[7:0], fb};
        end
        pn_short_step = {st, w};
    endfunction

    // APB decode
    assign idx = PADDR[13:2];
    assign wr_en = CE && PSEL && PENABLE && PWRITE && PREADY;

    always_comb begin
        rdata_next = '0;
        err_next = 1'b0;
        if (idx == IDX_TEST_SEL) begin
            rdata_next = {24'h000000, ctrl_reg};
        end else if (idx >= IDX_USER_BASE && idx <= IDX_USER_LAST) begin
            rdata_next = {24'h000000, user_reg[3'(idx - IDX_USER_BASE)]};
        end else if (idx == IDX_OUT_FMT) begin
            rdata_next = {30'h0, fmt_reg};
        end else if (idx == IDX_STATUS) begin
            rdata_next = {16'h0000, 3'h0, 5'(level), 2'(usr_idx_reg), usr_state_reg,
                ctrl_reg.code};
        end else begin
            err_next = 1'b1;
        end
        if (PADDR[1:0] != 2'h0) begin
            err_next = 1'b1;
        end
    end

    // Zero-wait answer, data captured in setup
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && err_next;
            if (PSEL && !PENABLE && !PWRITE) begin
                PRDATA <= rdata_next;
            end
        end
    end

    // Register writes
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_reg <= RST_TEST_SEL;
            fmt_reg <= RST_OUT_FMT[1:0];
            for (int i = 0; i < 2*OTPG_USER_N; i++) begin
                user_reg[i] <= RST_USER;
            end
        end else if (wr_en && !PSLVERR) begin
            if (idx == IDX_TEST_SEL) begin
                ctrl_reg <= PWDATA[7:0];
            end
            if (idx == IDX_OUT_FMT) begin
                fmt_reg <= PWDATA[1:0];
            end
            if (idx >= IDX_USER_BASE && idx <= IDX_USER_LAST) begin
                user_reg[3'(idx - IDX_USER_BASE)] <= PWDATA[7:0];
            end
        end
    end

    // Pattern selection
    assign pn_long_next = pn_long_step(pn_long_reg);
    assign pn_short_next = pn_short_step(pn_short_reg);
    assign user_pair = {user_reg[{usr_idx_reg, 1'b1}], user_reg[{usr_idx_reg, 1'b0}]};
    assign user_word = user_pair[15:2];

    always_comb begin
        case (ctrl_reg.code)
            CODE_MID: raw_word = WORD_MID;
            CODE_PFS: raw_word = WORD_PFS;
            CODE_NFS: raw_word = WORD_NFS;
            CODE_CHECK: raw_word = phase_reg ? WORD_CHECK_B : WORD_CHECK_A;
            CODE_PN_LONG: raw_word = pn_long_next[13:0];
            CODE_PN_SHORT: raw_word = pn_short_next[13:0];
            CODE_TOGGLE: raw_word = phase_reg ? WORD_ONES : WORD_ZERO;
            CODE_USER: raw_word = (usr_state_reg == USR_DONE) ? WORD_ZERO : user_word;
            CODE_RAMP: raw_word = ramp_reg;
            default: raw_word = WORD_ZERO;
        endcase
    end

    // Converter data only when off; fixed codes and ramp are formatted
    always_comb begin
        case (ctrl_reg.code)
            CODE_OFF: fifo_in = fmt_word(ADC_DATA, fmt_reg);
            CODE_MID, CODE_PFS, CODE_NFS, CODE_RAMP: fifo_in = fmt_word(raw_word, fmt_reg);
            default: fifo_in = raw_word;
        endcase
    end

    // No push in the cycle of a code change, so sequences start clean
    assign code_same = (ctrl_reg.code == code_prev_reg);
    assign push = CE && fifo_ready && code_same;

    // Pseudorandom generators
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pn_long_reg <= SEED_PN_LONG;
            pn_short_reg <= SEED_PN_SHORT;
        end else if (CE) begin
            if (ctrl_reg.rst_long) begin
                pn_long_reg <= SEED_PN_LONG;
            end else if (push && ctrl_reg.code == CODE_PN_LONG) begin
                pn_long_reg <= pn_long_next[36:14];
            end
            if (ctrl_reg.rst_short) begin
                pn_short_reg <= SEED_PN_SHORT;
            end else if (push && ctrl_reg.code == CODE_PN_SHORT) begin
                pn_short_reg <= pn_short_next[22:14];
            end
        end
    end

    // Alternation phase and ramp
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            phase_reg <= 1'b0;
            ramp_reg <= '0;
        end else if (CE) begin
            if (ctrl_reg.code != code_prev_reg) begin
                phase_reg <= 1'b0;
            end else if (push) begin
                phase_reg <= !phase_reg;
            end
            if (push && ctrl_reg.code == CODE_RAMP) begin
                ramp_reg <= ramp_reg + 14'h0001;
            end
        end
    end

    // User word sequencer
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            usr_idx_reg <= '0;
            usr_state_reg <= USR_RUN;
            code_prev_reg <= CODE_OFF;
        end else if (CE) begin
            code_prev_reg <= ctrl_reg.code;
            if (ctrl_reg.code != code_prev_reg) begin
                usr_idx_reg <= '0;
                usr_state_reg <= USR_RUN;
            end else if (push && ctrl_reg.code == CODE_USER) begin
                case (usr_state_reg)
                    USR_RUN: begin
                        usr_idx_reg <= usr_idx_reg + 2'h1;
                        if (ctrl_reg.single && usr_idx_reg == 2'h3) begin
                            usr_state_reg <= USR_DONE;
                        end
                    end
                    USR_DONE: usr_state_reg <= ctrl_reg.single ? USR_DONE : USR_RUN;
                    default: usr_state_reg <= USR_RUN;
                endcase
            end
        end
    end

    otpg_fifo #(.WIDTH(OTPG_W), .DEPTH(DEPTH)) u_fifo (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .ce(CE),
        .in_valid(code_same),
        .in_ready(fifo_ready),
        .in_data(fifo_in),
        .out_valid(OUT_VALID),
        .out_ready(OUT_READY),
        .out_data(OUT_DATA),
        .level(level)
    );

    // Checking aid: previous pushed word under same code
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            last_raw_reg <= '0;
            last_same_reg <= 1'b0;
        end else if (CE) begin
            if (ctrl_reg.code != code_prev_reg || ctrl_reg.rst_long || ctrl_reg.rst_short) begin
                last_same_reg <= 1'b0;
            end else if (push) begin
                last_raw_reg <= raw_word;
                last_same_reg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    a_off_passes_adc: assert property (
        push && ctrl_reg.code == CODE_OFF |-> fifo_in == fmt_word(ADC_DATA, fmt_reg))
        else $error("converter data not passed when off");
    a_fmt_offset_mid: assert property (
        ctrl_reg.code == CODE_MID && fmt_reg == FMT_OFFSET |-> fifo_in == 14'h2000)
        else $error("offset binary midscale wrong");
    a_pn_reseed: assert property (
        CE && ctrl_reg.rst_long |=> pn_long_reg == SEED_PN_LONG)
        else $error("long generator not reseeded");
    a_pn_short_reseed: assert property (
        CE && ctrl_reg.rst_short |=> pn_short_reg == SEED_PN_SHORT)
        else $error("short generator not reseeded");
    a_check_alt: assert property (
        push && ctrl_reg.code == CODE_CHECK && last_same_reg |-> raw_word != last_raw_reg
            && (raw_word == WORD_CHECK_A || raw_word == WORD_CHECK_B))
        else $error("checkerboard not alternating");
    a_toggle_alt: assert property (
        push && ctrl_reg.code == CODE_TOGGLE && last_same_reg |-> raw_word == ~last_raw_reg)
        else $error("word toggle not alternating");
    a_ramp_step: assert property (
        push && ctrl_reg.code == CODE_RAMP && last_same_reg |-> raw_word == last_raw_reg + 14'h0001)
        else $error("ramp step wrong");
    a_user_single: assert property (
        push && ctrl_reg.code == CODE_USER && ctrl_reg.single && usr_state_reg == USR_DONE
            |-> fifo_in == WORD_ZERO)
        else $error("single user mode not zero after four");
    a_user_repeat: assert property (
        push && ctrl_reg.code == CODE_USER && !ctrl_reg.single && usr_idx_reg == 2'h3
            && $stable(ctrl_reg) |=> ##[0:40] (usr_idx_reg == 2'h0))
        else $error("user words do not restart");
    a_pn_unformatted: assert property (
        push && ctrl_reg.code == CODE_PN_LONG |-> fifo_in == pn_long_next[13:0])
        else $error("long sequence word altered");
    a_pn_short_word: assert property (
        push && ctrl_reg.code == CODE_PN_SHORT |-> fifo_in == pn_short_next[13:0])
        else $error("short sequence word altered");
    a_const_pfs: assert property (
        ctrl_reg.code == CODE_PFS && fmt_reg == FMT_TWOS |-> fifo_in == WORD_PFS)
        else $error("full scale word wrong");
    a_freeze_ce: assert property (
        !CE |=> $stable(ramp_reg) && $stable(pn_long_reg) && $stable(phase_reg))
        else $error("state moved without clock enable");
    a_apb_answer: assert property (
        PSEL && !PENABLE && CE |=> PREADY)
        else $error("apb answer late");

    c_pn_long: cover property (push && ctrl_reg.code == CODE_PN_LONG);
    c_user_done: cover property (usr_state_reg == USR_DONE && ctrl_reg.code == CODE_USER);
    c_fifo_full: cover property (!fifo_ready);
    c_ramp_wrap: cover property (push && ctrl_reg.code == CODE_RAMP && ramp_reg == 14'h3FFF);
endmodule

// ==== dv/otpg_capture.sv ====
// Capture logic model that takes output words, optionally stalling
`timescale 1ns/10ps

module otpg_capture (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic stall,
    input wire logic slow,
    input wire logic [13:0] out_data,
    input wire logic out_valid,
    output logic out_ready
);
    logic [13:0] words[$];
    logic phase_reg;

    // Slow mode accepts every other cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end

    assign out_ready = !stall && !(slow && phase_reg);

    always @(posedge clk) begin
        if (rst_n && ce && out_valid === 1'b1 && out_ready) begin
            words.push_back(out_data);
        end
    end
endmodule

// ==== dv/otpg_top_test.sv ====
// Self-checking testbench of the test pattern generator
`timescale 1ns/10ps

module otpg_top_test
    import otpg_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [13:0] adc = 14'h1234;
    logic [13:0] odata;
    logic ovalid;
    logic oready;
    logic stall = 1'b1;
    logic slow = 1'b0;
    int err_total = 0;
    int total_checks = 0;
    logic [15:0] upat[4] = '{16'hABCD, 16'h1234, 16'hFFFC, 16'h5A5A};

    always #10 clk = ~clk;

    otpg_top #(.DEPTH(16)) i_dut (.REF_CLK(clk), .RESETN(rstn), .CE(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .ADC_DATA(adc), .OUT_DATA(odata),
        .OUT_VALID(ovalid), .OUT_READY(oready));

    otpg_capture i_cap (.clk(clk), .rst_n(rstn), .ce(ce), .stall(stall), .slow(slow),
        .out_data(odata), .out_valid(ovalid), .out_ready(oready));

    task automatic chk_word(input string nm, input logic [13:0] e, input logic [13:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_total++;
            $display("mismatch apb ready expected 1 seen %b", pready);
        end
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
        chk_reg("write error flag", 32'h0, {31'h0, e});
    endtask

    task automatic rd(input string nm, input logic [11:0] idx, input logic [31:0] x,
        input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        chk_reg({nm, " error flag"}, {31'h0, xe}, {31'h0, e});
        if (!xe) chk_reg(nm, x, r);
    endtask

    // Release the capture side and gather n words
    task automatic grab(input int n);
        int k;
        k = 0;
        i_cap.words.delete();
        stall <= 1'b0;
        while (i_cap.words.size() < n && k < 4 * n + 200) begin
            @(posedge clk);
            k++;
        end
        stall <= 1'b1;
        if (i_cap.words.size() < n) begin
            err_total++;
            $display("mismatch grab count expected %0d seen %0d", n, i_cap.words.size());
        end
    endtask

    task automatic find_seq(input string nm, input logic [13:0] e[$]);
        int s;
        bit ok;
        s = 0;
        for (int i = 0; i + e.size() <= i_cap.words.size(); i++) begin
            ok = 1;
            foreach (e[j]) if (i_cap.words[i + j] !== e[j]) ok = 0;
            if (ok) begin
                s = i;
                break;
            end
        end
        foreach (e[j]) chk_word(nm, e[j], (s + j < i_cap.words.size()) ? i_cap.words[s + j] : 'x);
    endtask

    function automatic logic [13:0] fmt_word(input logic [13:0] w, input int f);
        logic [13:0] ob;
        ob = w ^ 14'h2000;
        if (f == 0) return ob;
        if (f == 1) return w;
        return ob ^ (ob >> 1);
    endfunction

    task automatic s_regs();
        rd("test select reset", IDX_TEST_SEL, 32'h0, 1'b0);
        rd("format reset", IDX_OUT_FMT, 32'h1, 1'b0);
        wr(IDX_OUT_FMT, 8'h02);
        rd("format readback", IDX_OUT_FMT, 32'h2, 1'b0);
        rd("unmapped", 12'h600, 32'h0, 1'b1);
    endtask

    task automatic s_pass();
        wr(IDX_OUT_FMT, 8'h01);
        wr(IDX_TEST_SEL, 8'h00);
        grab(30);
        chk_word("code zero data", 14'h1234, i_cap.words[29]);
    endtask

    task automatic s_const();
        logic [13:0] base[3] = '{WORD_MID, WORD_PFS, WORD_NFS};
        for (int f = 0; f < 3; f++) begin
            wr(IDX_OUT_FMT, 8'(f));
            for (int c = 1; c < 4; c++) begin
                wr(IDX_TEST_SEL, 8'(c));
                grab(30);
                chk_word("constant", fmt_word(base[c - 1], f), i_cap.words[29]);
            end
        end
    endtask

    task automatic s_alt();
        wr(IDX_OUT_FMT, 8'h00);
        wr(IDX_TEST_SEL, 8'h04);
        grab(40);
        find_seq("checker", '{14'h1555, 14'h2AAA, 14'h1555, 14'h2AAA});
        wr(IDX_TEST_SEL, 8'h07);
        grab(40);
        find_seq("toggle", '{14'h0000, 14'h3FFF, 14'h0000, 14'h3FFF});
        wr(IDX_OUT_FMT, 8'h01);
    endtask

    task automatic s_pn();
        // Each generator runs first, so a missing reseed shows
        wr(IDX_TEST_SEL, 8'h05);
        grab(40);
        wr(IDX_TEST_SEL, 8'h15);
        repeat (20) @(posedge clk);
        wr(IDX_TEST_SEL, 8'h05);
        grab(40);
        find_seq("long pn", '{14'h3FD7, 14'h0002, 14'h26E0, 14'h0A3D, 14'h1CA6});
        wr(IDX_TEST_SEL, 8'h06);
        grab(40);
        wr(IDX_TEST_SEL, 8'h26);
        repeat (20) @(posedge clk);
        wr(IDX_TEST_SEL, 8'h06);
        grab(40);
        find_seq("short pn", '{14'h125B, 14'h3C9A, 14'h2660, 14'h0C65, 14'h0697});
    endtask

    task automatic s_user();
        logic [13:0] p[4];
        for (int i = 0; i < 4; i++) begin
            wr(IDX_USER_BASE + 12'(2 * i), upat[i][7:0]);
            wr(IDX_USER_BASE + 12'(2 * i + 1), upat[i][15:8]);
            p[i] = upat[i][15:2];
        end
        slow <= 1'b1;
        wr(IDX_TEST_SEL, 8'h08);
        grab(40);
        find_seq("user repeat", '{p[0], p[1], p[2], p[3], p[0], p[1]});
        slow <= 1'b0;
        wr(IDX_TEST_SEL, 8'h07);
        wr(IDX_TEST_SEL, 8'h88);
        grab(40);
        find_seq("user single", '{p[0], p[1], p[2], p[3], 14'h0, 14'h0});
        chk_word("user single tail", 14'h0000, i_cap.words[39]);
        repeat (20) @(posedge clk);
        rd("status single done", IDX_STATUS, 32'h00001028, 1'b0);
    endtask

    task automatic s_ramp();
        int n;
        logic [13:0] lastw;
        wr(IDX_TEST_SEL, 8'h0F);
        grab(16500);
        // First 17 words are left over from the previous pattern
        chk_word("ramp start", 14'h0000, i_cap.words[17]);
        for (int i = 18; i < i_cap.words.size(); i++) begin
            chk_word("ramp step", i_cap.words[i - 1] + 14'h1, i_cap.words[i]);
        end
        @(posedge clk);
        n = i_cap.words.size();
        lastw = i_cap.words[n - 1];
        ce <= 1'b0;
        stall <= 1'b0;
        repeat (20) @(posedge clk);
        chk_reg("words while disabled", 32'(n), 32'(i_cap.words.size()));
        ce <= 1'b1;
        grab(40);
        chk_word("ramp after disable", lastw + 14'h1, i_cap.words[0]);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        s_regs();
        s_pass();
        s_const();
        s_alt();
        s_pn();
        s_user();
        s_ramp();
        tally_and_finish();
    end
endmodule
